// ==== src/fsd_pkg.sv ====
// Purpose: constants and state type for the pointer subtract and indexed
//          offset decode block
// Assumes: 32-bit register bus, 12-bit data memory addresses
// Notes:   register offsets are byte addresses of aligned words
package fsd_pkg;

  // widths
  localparam int PTR_W  = 12;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int PC_W   = 21;

  // register offsets
  localparam logic [ADDR_W-1:0] REG_CTRL   = 5'h00;
  localparam logic [ADDR_W-1:0] REG_PTR0   = 5'h04;
  localparam logic [ADDR_W-1:0] REG_PTR1   = 5'h08;
  localparam logic [ADDR_W-1:0] REG_PTR2   = 5'h0C;
  localparam logic [ADDR_W-1:0] REG_STATUS = 5'h10;

  // field positions
  localparam int CTRL_EXT_BIT    = 0;
  localparam int CTRL_BANK_LSB   = 4;
  localparam int CTRL_BANK_MSB   = 7;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_EXT_BIT  = 1;
  localparam int OPC_HI_LSB      = 8;
  localparam int OPC_SEL_LSB     = 6;
  localparam int ACCESS_BIT      = 8;
  localparam int DEST_BIT        = 9;

  // reset values
  localparam logic             EXT_RST  = 1'b0;
  localparam logic [3:0]       BANK_RST = 4'h0;
  localparam logic [PTR_W-1:0] PTR_RST  = 12'h000;
  localparam logic [PC_W-1:0]  PC_RST   = 21'h000000;

  // encodings
  localparam logic [7:0] SUB_OPCODE       = 8'hE9;
  localparam logic [1:0] SEL_RETURN       = 2'h3;
  localparam logic [1:0] SEL_THIRD        = 2'h2;
  localparam logic [7:0] INDEX_LIMIT      = 8'h5F;
  localparam logic [3:0] ACCESS_LOW_BANK  = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

  typedef struct packed {
    logic [2:0][PTR_W-1:0] ptr;
    logic                  ext_en;
    logic [3:0]            bank;
    logic                  ret_busy;
    logic                  bus_ack;
    logic [DATA_W-1:0]     rdata;
    logic                  pc_load;
    logic                  stack_pop;
    logic [PC_W-1:0]       pc_value;
    logic                  oper_valid;
    logic [PTR_W-1:0]      oper_addr;
    logic                  oper_indexed;
    logic                  oper_dest_file;
  } fsd_state_t;

endpackage : fsd_pkg

// ==== src/fsd_addr_resolve.sv ====
// Purpose: operand address resolution for byte and bit oriented opcodes
// Assumes: pure combinational, caller registers the result
// Notes:   low offsets index from the third pointer when extended set is on
module fsd_addr_resolve (
  // mode
  input  wire logic                     ext_en,
  input  wire logic [3:0]               bank,
  input  wire logic [fsd_pkg::PTR_W-1:0] third_ptr,
  // opcode fields
  input  wire logic                     access_sel,
  input  wire logic [7:0]               file_addr,
  // result
  output logic      [fsd_pkg::PTR_W-1:0] addr,
  output logic                          indexed
);

  logic low_half;

  assign low_half = (file_addr <= fsd_pkg::INDEX_LIMIT);

  always_comb begin
    indexed = 1'b0;
    if (access_sel) begin
      addr = {bank, file_addr};
    end else if (ext_en && low_half) begin
      // 12-bit wrap covers the whole data space
      addr    = third_ptr + {4'h0, file_addr};
      indexed = 1'b1;
    end else if (low_half) begin
      addr = {fsd_pkg::ACCESS_LOW_BANK, file_addr};
    end else begin
      addr = {fsd_pkg::ACCESS_HIGH_BANK, file_addr};
    end
  end

endmodule : fsd_addr_resolve

// ==== src/fsd_decoder.sv ====
// Purpose: pointer subtract, subtract-and-return and indexed offset decode
// Assumes: fetch path flags byte/bit oriented words; single core clock
// Notes:   registers on Avalon-MM, one wait state per access
//
// Summary of operation
// - subtract opcode: pointer 0..2 minus 6-bit literal, written back
// - select 11: third pointer minus literal, then pc from stack top
// - subtract-and-return takes two cycles, second idle; plain takes one
// - extended off: access bank when a is 0, bank register when a is 1
// - extended on, a 0, address up to 5Fh: third pointer plus offset
// - addresses above 5Fh keep literal access bank meaning
// - third pointer zero maps offsets onto original low access locations
// - destination bit unchanged in indexed mode, only address changes
// - extended on decodes new opcodes and switches to indexed resolution
// - destination 0 writes working register, 1 writes file register
// - indexed addresses reach all of the 4096-byte data space
//
// Register access over Avalon-MM and the address map were chosen for this implementation.
module fsd_decoder (
  // clock and reset
  input  wire logic                          clock,
  input  wire logic                          sys_rst,
  // register bus
  input  wire logic [fsd_pkg::ADDR_W-1:0]    avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [fsd_pkg::DATA_W-1:0]    avs_writedata,
  output logic      [fsd_pkg::DATA_W-1:0]    avs_readdata,
  output logic                               avs_waitrequest,
  // instruction fetch
  input  wire logic                          instr_valid,
  input  wire logic [15:0]                   instr_word,
  input  wire logic                          instr_file_op,
  input  wire logic                          instr_byte_op,
  output logic                               instr_ready,
  // return stack and program counter
  input  wire logic [fsd_pkg::PC_W-1:0]      return_stack_top,
  output logic                               stack_pop,
  output logic                               pc_load,
  output logic      [fsd_pkg::PC_W-1:0]      pc_load_value,
  // operand path
  output logic                               oper_valid,
  output logic      [fsd_pkg::PTR_W-1:0]     oper_addr,
  output logic                               oper_indexed,
  output logic                               oper_dest_file,
  output logic      [fsd_pkg::PTR_W-1:0]     third_file_pointer
);

  fsd_pkg::fsd_state_t st_reg;
  fsd_pkg::fsd_state_t st_next;

  logic                      instr_fire;
  logic                      sub_fire;
  logic                      ret_fire;
  logic                      plain_fire;
  logic                      file_fire;
  logic [1:0]                sub_idx;
  logic [5:0]                sub_lit;
  logic [fsd_pkg::PTR_W-1:0] sub_diff;
  logic [fsd_pkg::PTR_W-1:0] res_addr;
  logic                      res_indexed;
  logic                      bus_req;
  logic                      bus_wr;
  logic [fsd_pkg::DATA_W-1:0] rd_mux;

  // instruction side decode
  assign instr_ready = ~st_reg.ret_busy;
  assign instr_fire  = instr_valid & instr_ready;
  assign sub_fire    = instr_fire & st_reg.ext_en &
                       (instr_word[15:fsd_pkg::OPC_HI_LSB] ==
                        fsd_pkg::SUB_OPCODE);
  assign ret_fire    = sub_fire &
                       (instr_word[7:fsd_pkg::OPC_SEL_LSB] ==
                        fsd_pkg::SEL_RETURN);
  assign plain_fire  = sub_fire & ~ret_fire;
  assign file_fire   = instr_fire & instr_file_op & ~sub_fire;
  assign sub_lit     = instr_word[5:0];
  assign sub_idx     = ret_fire ? fsd_pkg::SEL_THIRD
                                : instr_word[7:fsd_pkg::OPC_SEL_LSB];

  // unsigned subtract, wraps below zero, no flags produced
  always_comb begin
    unique case (sub_idx)
      2'h0:    sub_diff = st_reg.ptr[0] - {6'h00, sub_lit};
      2'h1:    sub_diff = st_reg.ptr[1] - {6'h00, sub_lit};
      default: sub_diff = st_reg.ptr[2] - {6'h00, sub_lit};
    endcase
  end

  fsd_addr_resolve u_resolve (
    .ext_en     (st_reg.ext_en),
    .bank       (st_reg.bank),
    .third_ptr  (st_reg.ptr[2]),
    .access_sel (instr_word[fsd_pkg::ACCESS_BIT]),
    .file_addr  (instr_word[7:0]),
    .addr       (res_addr),
    .indexed    (res_indexed)
  );

  // bus side: one wait state, write lands on the acknowledging edge
  assign bus_req         = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~st_reg.bus_ack;
  assign bus_wr          = avs_write & st_reg.bus_ack;

  always_comb begin
    rd_mux = '0;
    unique case (avs_address)
      fsd_pkg::REG_CTRL: begin
        rd_mux[fsd_pkg::CTRL_EXT_BIT] = st_reg.ext_en;
        rd_mux[fsd_pkg::CTRL_BANK_MSB:fsd_pkg::CTRL_BANK_LSB] = st_reg.bank;
      end
      fsd_pkg::REG_PTR0: rd_mux[fsd_pkg::PTR_W-1:0] = st_reg.ptr[0];
      fsd_pkg::REG_PTR1: rd_mux[fsd_pkg::PTR_W-1:0] = st_reg.ptr[1];
      fsd_pkg::REG_PTR2: rd_mux[fsd_pkg::PTR_W-1:0] = st_reg.ptr[2];
      fsd_pkg::REG_STATUS: begin
        rd_mux[fsd_pkg::STATUS_BUSY_BIT] = st_reg.ret_busy;
        rd_mux[fsd_pkg::STATUS_EXT_BIT]  = st_reg.ext_en;
      end
      default: rd_mux = '0;
    endcase
  end

  always_comb begin
    st_next            = st_reg;
    st_next.pc_load    = 1'b0;
    st_next.stack_pop  = 1'b0;
    st_next.oper_valid = 1'b0;
    st_next.bus_ack    = bus_req & ~st_reg.bus_ack;
    // second cycle of subtract-and-return does nothing
    st_next.ret_busy   = 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (sub_fire && (sub_idx == i[1:0])) begin
        st_next.ptr[i] = sub_diff;
      end
    end
    if (ret_fire) begin
      st_next.pc_load   = 1'b1;
      st_next.stack_pop = 1'b1;
      st_next.pc_value  = return_stack_top;
      st_next.ret_busy  = 1'b1;
    end
    if (file_fire) begin
      st_next.oper_valid     = 1'b1;
      st_next.oper_addr      = res_addr;
      st_next.oper_indexed   = res_indexed;
      // d keeps its meaning whatever the address mode
      st_next.oper_dest_file = instr_byte_op &
                               instr_word[fsd_pkg::DEST_BIT];
    end
    if (bus_req && !st_reg.bus_ack) begin
      st_next.rdata = rd_mux;
    end
    // bus write wins over a same-cycle subtract
    if (bus_wr) begin
      unique case (avs_address)
        fsd_pkg::REG_CTRL: begin
          st_next.ext_en = avs_writedata[fsd_pkg::CTRL_EXT_BIT];
          st_next.bank   =
            avs_writedata[fsd_pkg::CTRL_BANK_MSB:fsd_pkg::CTRL_BANK_LSB];
        end
        fsd_pkg::REG_PTR0: st_next.ptr[0] =
                             avs_writedata[fsd_pkg::PTR_W-1:0];
        fsd_pkg::REG_PTR1: st_next.ptr[1] =
                             avs_writedata[fsd_pkg::PTR_W-1:0];
        fsd_pkg::REG_PTR2: st_next.ptr[2] =
                             avs_writedata[fsd_pkg::PTR_W-1:0];
        default: st_next.bank = st_next.bank;
      endcase
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg.ptr            <= {3{fsd_pkg::PTR_RST}};
      st_reg.ext_en         <= fsd_pkg::EXT_RST;
      st_reg.bank           <= fsd_pkg::BANK_RST;
      st_reg.ret_busy       <= 1'b0;
      st_reg.bus_ack        <= 1'b0;
      st_reg.rdata          <= '0;
      st_reg.pc_load        <= 1'b0;
      st_reg.stack_pop      <= 1'b0;
      st_reg.pc_value       <= fsd_pkg::PC_RST;
      st_reg.oper_valid     <= 1'b0;
      st_reg.oper_addr      <= fsd_pkg::PTR_RST;
      st_reg.oper_indexed   <= 1'b0;
      st_reg.oper_dest_file <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign avs_readdata       = st_reg.rdata;
  assign stack_pop          = st_reg.stack_pop;
  assign pc_load            = st_reg.pc_load;
  assign pc_load_value      = st_reg.pc_value;
  assign oper_valid         = st_reg.oper_valid;
  assign oper_addr          = st_reg.oper_addr;
  assign oper_indexed       = st_reg.oper_indexed;
  assign oper_dest_file     = st_reg.oper_dest_file;
  assign third_file_pointer = st_reg.ptr[2];

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_ret_first;
    pc_load && stack_pop && !instr_ready;
  endsequence

  sequence s_ret_idle;
    instr_ready && !pc_load && !stack_pop;
  endsequence

  a_sub_literal_value: assert property (
    plain_fire && !bus_wr |=>
      st_reg.ptr[$past(sub_idx)] == $past(sub_diff))
    else $error("pointer subtract result wrong");

  a_ret_third_only: assert property (
    ret_fire && !bus_wr |=>
      st_reg.ptr[2] == $past(st_reg.ptr[2]) - {6'h00, $past(sub_lit)} &&
      $stable(st_reg.ptr[0]) && $stable(st_reg.ptr[1]))
    else $error("subtract-and-return touched wrong pointer");

  a_ret_pc_load: assert property (
    ret_fire |=> pc_load_value == $past(return_stack_top))
    else $error("pc not loaded from stack top");

  a_ret_two_cycles: assert property (
    ret_fire |=> s_ret_first ##1 s_ret_idle)
    else $error("subtract-and-return not two cycles");

  a_sub_one_cycle: assert property (
    plain_fire |=> instr_ready && !pc_load)
    else $error("plain subtract stalled or returned");

  a_literal_bank: assert property (
    file_fire && !st_reg.ext_en && instr_word[fsd_pkg::ACCESS_BIT] |=>
      oper_addr == {$past(st_reg.bank), $past(instr_word[7:0])})
    else $error("banked literal address wrong");

  a_indexed_addr: assert property (
    file_fire && st_reg.ext_en && !instr_word[fsd_pkg::ACCESS_BIT] &&
    instr_word[7:0] <= fsd_pkg::INDEX_LIMIT |=>
      oper_indexed &&
      oper_addr == $past(st_reg.ptr[2]) + {4'h0, $past(instr_word[7:0])})
    else $error("indexed address wrong");

  a_high_literal: assert property (
    file_fire && st_reg.ext_en && !instr_word[fsd_pkg::ACCESS_BIT] &&
    instr_word[7:0] > fsd_pkg::INDEX_LIMIT |=>
      !oper_indexed &&
      oper_addr == {fsd_pkg::ACCESS_HIGH_BANK, $past(instr_word[7:0])})
    else $error("high access address reinterpreted");

  a_zero_ptr_map: assert property (
    file_fire && st_reg.ext_en && st_reg.ptr[2] == fsd_pkg::PTR_RST &&
    !instr_word[fsd_pkg::ACCESS_BIT] &&
    instr_word[7:0] <= fsd_pkg::INDEX_LIMIT |=>
      oper_addr == {fsd_pkg::ACCESS_LOW_BANK, $past(instr_word[7:0])})
    else $error("zero pointer does not map to access bank");

  a_dest_bit_kept: assert property (
    file_fire && instr_byte_op |=>
      oper_valid && oper_dest_file == $past(instr_word[fsd_pkg::DEST_BIT]))
    else $error("destination bit altered");

  a_ext_gate_sub: assert property (
    instr_fire && !st_reg.ext_en && !bus_wr |=>
      !pc_load && $stable(st_reg.ptr))
    else $error("extended opcode ran with set disabled");

  a_low_literal: assert property (
    file_fire && !st_reg.ext_en && !instr_word[fsd_pkg::ACCESS_BIT] |=>
      !oper_indexed && oper_addr[7:0] == $past(instr_word[7:0]))
    else $error("access bank literal address wrong");

  a_bit_op_dest: assert property (
    file_fire && !instr_byte_op |=> oper_valid && !oper_dest_file)
    else $error("bit oriented opcode wrote file destination");

  a_oper_strobe: assert property (
    !file_fire |=> !oper_valid)
    else $error("operand strobe without an accepted opcode");

  a_pop_with_load: assert property (
    stack_pop == pc_load)
    else $error("stack pop and pc load out of step");

  a_ptr0_quiet: assert property (
    !(plain_fire && sub_idx == 2'h0) && !bus_wr |=>
      $stable(st_reg.ptr[0]))
    else $error("pointer 0 changed without a cause");

  a_ptr1_quiet: assert property (
    !(plain_fire && sub_idx == 2'h1) && !bus_wr |=>
      $stable(st_reg.ptr[1]))
    else $error("pointer 1 changed without a cause");

  a_ptr2_quiet: assert property (
    !(sub_fire && sub_idx == fsd_pkg::SEL_THIRD) && !bus_wr |=>
      $stable(st_reg.ptr[2]))
    else $error("third pointer changed without a cause");

endmodule : fsd_decoder

// ==== testbench/fsd_far_model.sv ====
// Purpose: far side model, return stack and program counter
// Assumes: pop and load arrive as one-cycle pulses
// Notes:   stack entries are preset to fixed return addresses
module fsd_far_model (
  // clock and reset
  input  wire logic                     clock,
  input  wire logic                     sys_rst,
  // core side
  input  wire logic                     stack_pop,
  input  wire logic                     pc_load,
  input  wire logic [fsd_pkg::PC_W-1:0] pc_load_value,
  output logic      [fsd_pkg::PC_W-1:0] return_stack_top,
  output logic      [fsd_pkg::PC_W-1:0] pc
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [fsd_pkg::PC_W-1:0] stack [4];
  logic [1:0]               depth;
  assign return_stack_top = stack[depth - 2'h1];
  initial begin
    for (int i = 0; i < 4; i++) begin
      stack[i] = 21'h010000 + 21'(i);
    end
  end
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pc    <= '0;
      depth <= 2'h2;
    end else begin
      if (pc_load) begin
        pc <= pc_load_value;
      end
      if (stack_pop) begin
        depth <= depth - 2'h1;
      end
    end
  end
endmodule : fsd_far_model

// ==== testbench/tb.sv ====
// Purpose: self-checking bench for the pointer subtract and offset decode
// Assumes: one wait state bus, one-cycle instruction answer
// Notes:   expectations are worked out by hand from the opcode fields
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                          clock = 1'b0;
  logic                          sys_rst = 1'b1;
  logic [fsd_pkg::ADDR_W-1:0]    avs_address = '0;
  logic                          avs_read = 1'b0;
  logic                          avs_write = 1'b0;
  logic [fsd_pkg::DATA_W-1:0]    avs_writedata = '0;
  logic [fsd_pkg::DATA_W-1:0]    avs_readdata;
  logic                          avs_waitrequest;
  logic                          instr_valid = 1'b0;
  logic [15:0]                   instr_word = '0;
  logic                          instr_file_op = 1'b0;
  logic                          instr_byte_op = 1'b0;
  logic                          instr_ready;
  logic                          stack_pop;
  logic                          pc_load;
  logic [fsd_pkg::PC_W-1:0]      pc_load_value;
  logic [fsd_pkg::PC_W-1:0]      stack_top;
  logic [fsd_pkg::PC_W-1:0]      pc;
  logic                          oper_valid;
  logic [fsd_pkg::PTR_W-1:0]     oper_addr;
  logic                          oper_indexed;
  logic                          oper_dest_file;
  logic [fsd_pkg::PTR_W-1:0]     third_ptr;
  int                            n_mismatch = 0;
  int                            cmp_count = 0;
  int                            cycles = 0;

  fsd_decoder u_dut (.clock(clock), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_file_op(instr_file_op),
    .instr_byte_op(instr_byte_op), .instr_ready(instr_ready),
    .return_stack_top(stack_top), .stack_pop(stack_pop),
    .pc_load(pc_load), .pc_load_value(pc_load_value),
    .oper_valid(oper_valid), .oper_addr(oper_addr),
    .oper_indexed(oper_indexed), .oper_dest_file(oper_dest_file),
    .third_file_pointer(third_ptr));

  fsd_far_model u_far (.clock(clock), .sys_rst(sys_rst),
    .stack_pop(stack_pop), .pc_load(pc_load),
    .pc_load_value(pc_load_value), .return_stack_top(stack_top), .pc(pc));

  always #5 clock = ~clock;

  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [fsd_pkg::ADDR_W-1:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clock);
    avs_address   <= a;
    avs_writedata <= wd;
    avs_read      <= !wr;
    avs_write     <= wr;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) @(posedge clock);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wreg(input logic [fsd_pkg::ADDR_W-1:0] a,
                      input logic [31:0] d);
    logic [31:0] rd;
    bus(1'b1, a, d, rd);
  endtask : wreg

  task automatic rreg(input logic [fsd_pkg::ADDR_W-1:0] a,
                      input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, a, '0, rd);
    check("register", exp, rd);
  endtask : rreg

  // ends in the cycle after the accepting edge
  task automatic issue(input logic [15:0] w, input logic fo,
                       input logic bo);
    @(posedge clock);
    instr_word    <= w;
    instr_file_op <= fo;
    instr_byte_op <= bo;
    instr_valid   <= 1'b1;
    @(posedge clock);
    while (instr_ready !== 1'b1) @(posedge clock);
    instr_valid <= 1'b0;
    @(negedge clock);
  endtask : issue

  task automatic fop(input logic [15:0] w, input logic bo,
                     input logic [11:0] adr, input logic idx,
                     input logic dst);
    issue(w, 1'b1, bo);
    check("oper_valid", 32'h1, 32'(oper_valid));
    check("oper_addr", 32'(adr), 32'(oper_addr));
    check("oper_indexed", 32'(idx), 32'(oper_indexed));
    check("oper_dest_file", 32'(dst), 32'(oper_dest_file));
    @(negedge clock);
    check("oper_valid gone", 32'h0, 32'(oper_valid));
  endtask : fop

  task automatic t_reset();
    rreg(fsd_pkg::REG_CTRL, 32'h0);
    rreg(fsd_pkg::REG_PTR2, 32'h0);
    rreg(fsd_pkg::REG_STATUS, 32'h0);
    wreg(5'h14, 32'hFFFFFFFF);
    rreg(5'h14, 32'h0);
    rreg(fsd_pkg::REG_CTRL, 32'h0);
  endtask : t_reset

  task automatic t_legacy();
    wreg(fsd_pkg::REG_CTRL, 32'h50);
    wreg(fsd_pkg::REG_PTR0, 32'h100);
    wreg(fsd_pkg::REG_PTR2, 32'hA00);
    issue(16'hE905, 1'b0, 1'b0);
    rreg(fsd_pkg::REG_PTR0, 32'h100);
    fop(16'h2410, 1'b1, 12'h010, 1'b0, 1'b0);
    fop(16'h2680, 1'b1, 12'hF80, 1'b0, 1'b1);
    fop(16'h252C, 1'b1, 12'h52C, 1'b0, 1'b0);
  endtask : t_legacy

  task automatic t_sub();
    wreg(fsd_pkg::REG_CTRL, 32'h51);
    wreg(fsd_pkg::REG_PTR1, 32'h020);
    wreg(fsd_pkg::REG_PTR2, 32'h3FF);
    rreg(fsd_pkg::REG_STATUS, 32'h2);
    issue(16'hE93F, 1'b0, 1'b0);
    check("ready plain", 32'h1, 32'(instr_ready));
    check("pc_load plain", 32'h0, 32'(pc_load));
    issue(16'hE97F, 1'b0, 1'b0);
    issue(16'hE9A3, 1'b0, 1'b0);
    rreg(fsd_pkg::REG_PTR0, 32'h0C1);
    rreg(fsd_pkg::REG_PTR1, 32'hFE1);
    check("third ptr", 32'h3DC, 32'(third_ptr));
  endtask : t_sub

  task automatic t_ret();
    issue(16'hE9E3, 1'b0, 1'b0);
    check("third ptr ret", 32'h3B9, 32'(third_ptr));
    check("pc_load", 32'h1, 32'(pc_load));
    check("stack_pop", 32'h1, 32'(stack_pop));
    check("pc value", 32'h010001, 32'(pc_load_value));
    check("ready idle", 32'h0, 32'(instr_ready));
    @(negedge clock);
    check("pc_load end", 32'h0, 32'(pc_load));
    check("ready back", 32'h1, 32'(instr_ready));
    check("far pc", 32'h010001, 32'(pc));
    rreg(fsd_pkg::REG_PTR0, 32'h0C1);
  endtask : t_ret

  task automatic t_index();
    wreg(fsd_pkg::REG_PTR2, 32'hA00);
    fop(16'h242C, 1'b1, 12'hA2C, 1'b1, 1'b0);
    fop(16'h265F, 1'b1, 12'hA5F, 1'b1, 1'b1);
    fop(16'h2460, 1'b1, 12'hF60, 1'b0, 1'b0);
    fop(16'h2510, 1'b1, 12'h510, 1'b0, 1'b0);
    fop(16'h8005, 1'b0, 12'hA05, 1'b1, 1'b0);
    wreg(fsd_pkg::REG_PTR2, 32'hFA0);
    fop(16'h245F, 1'b1, 12'hFFF, 1'b1, 1'b0);
    wreg(fsd_pkg::REG_PTR2, 32'h000);
    fop(16'h2410, 1'b1, 12'h010, 1'b1, 1'b0);
  endtask : t_index

  initial begin
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
    t_legacy();
    t_sub();
    t_ret();
    t_index();
    complete_run();
  end
endmodule : tb
